// *** pfms_defs.vh ***
// Register offsets, field positions, reset values and timing counts for the port mode block
`ifndef PFMS_DEFS_VH
`define PFMS_DEFS_VH
`define PFMS_CFG_BASE      8'h00
`define PFMS_THR_BASE      8'h30
`define PFMS_IN_DATA       8'h60
`define PFMS_EVT_MASK      8'h64
`define PFMS_IN_MODE       8'h68
`define PFMS_IRQ_STATUS    8'h6c
`define PFMS_IRQ_MASK      8'h70
`define PFMS_MODE_HI       15
`define PFMS_MODE_LO       12
`define PFMS_MODE_HIZ      4'h0
`define PFMS_MODE_THRIN    4'h1
`define PFMS_MODE_XLAT     4'h2
`define PFMS_CFG_RESET     16'h0000
`define PFMS_THR_RESET     12'h000
`define PFMS_MASK_RESET    12'hfff
`define PFMS_SETTLE_US     1000
`define PFMS_CLK_MHZ       10
`define PFMS_SETTLE_CYC    (`PFMS_SETTLE_US * `PFMS_CLK_MHZ)
`endif

// *** pfms_port_mem.v ***
// Small register memory holding per-port configuration words
`timescale 1ns/1ps
module pfms_port_mem #(
  parameter WIDTH = 16,
  parameter DEPTH = 12,
  parameter AW    = 4
) (
  // Clock and reset
  input  wire             aclk,
  input  wire             aresetn,
  // Write port
  input  wire             wr_en,
  input  wire [AW-1:0]    wr_addr,
  input  wire [WIDTH-1:0] wr_data,
  // Registered read port
  input  wire [AW-1:0]    rd_addr,
  output reg  [WIDTH-1:0] rd_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1]; // Storage words
  integer i;

  // Write and clear; reset zeroes so modes start in high impedance
  always @(posedge aclk) begin
    if (!aresetn) begin
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem[i] <= {WIDTH{1'b0}};
      end
    end else if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Read data from a register
  always @(posedge aclk) begin
    if (!aresetn) begin
      rd_data <= {WIDTH{1'b0}};
    end else begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule

// *** pfms_port_mode.v ***
// Per-port function mode selection with thresholded input and translator pairs
//
// Contract
// - Mode field bits 15:12 picks each port's function
// - Code 0000 keeps port undriven and unused
// - Code 0001 thresholded input, above threshold reads one
// - Threshold takes up to 1ms to apply
// - Comparison result readable in input data register
// - Code 0010 pairs port with next, neighbour hiz
// - Translator activity seen through input path
`timescale 1ns/1ps
`include "pfms_defs.vh"
module pfms_port_mode #(
  parameter NPORT      = 12,
  parameter THR_W      = 12,
  parameter SETTLE_CYC = `PFMS_SETTLE_CYC
) (
  // Clock and reset
  input  wire                   aclk,
  input  wire                   aresetn,
  // AXI4-Lite write address
  input  wire [7:0]             s_axi_awaddr,
  input  wire                   s_axi_awvalid,
  output wire                   s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0]            s_axi_wdata,
  input  wire [3:0]             s_axi_wstrb,
  input  wire                   s_axi_wvalid,
  output wire                   s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]             s_axi_bresp,
  output reg                    s_axi_bvalid,
  input  wire                   s_axi_bready,
  // AXI4-Lite read address
  input  wire [7:0]             s_axi_araddr,
  input  wire                   s_axi_arvalid,
  output wire                   s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0]            s_axi_rdata,
  output reg  [1:0]             s_axi_rresp,
  output reg                    s_axi_rvalid,
  input  wire                   s_axi_rready,
  // Port pins: comparator results in, drive out
  input  wire [NPORT-1:0]       pin_above_thr,
  output reg  [NPORT-1:0]       pin_out,
  output reg  [NPORT-1:0]       pin_oe,
  // Thresholds toward the analogue comparators
  output reg  [NPORT*THR_W-1:0] thr_level,
  // Interrupt
  output wire                   irq
);
  // Register state
  reg  [3:0]       mode [0:NPORT-1];   // Mode field copy per port
  reg  [THR_W-1:0] thr  [0:NPORT-1];   // Threshold words
  reg  [NPORT-1:0] evt_mask;           // input_event_mask_bit per port
  reg  [NPORT-1:0] in_mode;            // input_detect_mode_bit per port
  reg  [NPORT-1:0] irq_status;         // Sticky input events
  reg  [NPORT-1:0] irq_mask;           // Interrupt enable mask
  reg  [NPORT-1:0] in_level;           // input_level_result_bit per port
  reg  [NPORT-1:0] settled;            // Threshold has taken effect
  reg  [13:0]      settle_cnt [0:NPORT-1];
  reg  [NPORT-1:0] xlat_rel;           // Translator pair in release lockout
  // Pin synchronisers
  reg  [NPORT-1:0] sync1;              // First stage, read only by sync2
  reg  [NPORT-1:0] sync2;
  reg  [NPORT-1:0] sync3;
  reg  [NPORT-1:0] stable;             // Filtered pin level
  // Bus state
  reg              aw_hold;
  reg              w_hold;
  reg  [7:0]       aw_addr;
  reg  [31:0]      w_data;
  reg  [3:0]       w_strb;
  reg  [3:0]       mem_rd_addr;
  wire [15:0]      mem_rd_data;
  reg              rd_pend;
  reg  [31:0]      rd_mux;
  reg              rd_from_mem;
  integer          k;

  // Port index of an address inside a bank, or 15 if outside
  function [3:0] port_of;
    input [7:0] addr;
    input [7:0] base;
    reg   [7:0] off;
    begin
      off = addr - base;
      if (addr >= base && off[1:0] == 2'b00 && off[7:2] < NPORT)
        port_of = off[5:2];
      else
        port_of = 4'hf;
    end
  endfunction

  // Mode used as input path: thresholded input or translator
  function is_input_mode;
    input [3:0] m;
    begin
      is_input_mode = (m == `PFMS_MODE_THRIN) || (m == `PFMS_MODE_XLAT);
    end
  endfunction

  wire       do_write = aw_hold && w_hold && !s_axi_bvalid;
  wire [3:0] cfg_wr_port = port_of(aw_addr, `PFMS_CFG_BASE);
  wire [3:0] thr_wr_port = port_of(aw_addr, `PFMS_THR_BASE);
  wire [15:0] cfg_wdata  = {w_strb[1] ? w_data[15:8] : mem_rd_data[15:8],
                            w_strb[0] ? w_data[7:0] : mem_rd_data[7:0]};

  assign s_axi_awready = !aw_hold;
  assign s_axi_wready  = !w_hold;
  // Refuse reads while a config write owns the memory read port, so a handshake is a take
  assign s_axi_arready = !rd_pend && !s_axi_rvalid && !(do_write && cfg_wr_port != 4'hf);
  assign irq           = |(irq_status & irq_mask);

  // Config words stored in memory; full words kept for readback
  pfms_port_mem #(.WIDTH(16), .DEPTH(NPORT), .AW(4)) u_cfg_mem (
    .aclk    (aclk),
    .aresetn (aresetn),
    .wr_en   (do_write && cfg_wr_port != 4'hf && (w_strb[1:0] == 2'b11)),
    .wr_addr (cfg_wr_port),
    .wr_data (cfg_wdata),
    .rd_addr (mem_rd_addr),
    .rd_data (mem_rd_data)
  );

  // Write channel capture and response
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold      <= 1'b0;
      w_hold       <= 1'b0;
      aw_addr      <= 8'h00;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
    end else begin
      if (s_axi_awvalid && !aw_hold) begin
        aw_hold <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_hold) begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_hold      <= 1'b0;
        w_hold       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // Unmapped addresses answer decode error
        if (cfg_wr_port != 4'hf || thr_wr_port != 4'hf ||
            aw_addr == `PFMS_EVT_MASK || aw_addr == `PFMS_IN_MODE ||
            aw_addr == `PFMS_IRQ_STATUS || aw_addr == `PFMS_IRQ_MASK ||
            aw_addr == `PFMS_IN_DATA)
          s_axi_bresp <= 2'b00;
        else
          s_axi_bresp <= 2'b11;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Register writes, threshold settle timers and mode copies
  always @(posedge aclk) begin
    if (!aresetn) begin
      evt_mask <= `PFMS_MASK_RESET;
      in_mode  <= {NPORT{1'b0}};
      irq_mask <= {NPORT{1'b0}};
      settled  <= {NPORT{1'b0}};
      for (k = 0; k < NPORT; k = k + 1) begin
        mode[k]       <= `PFMS_MODE_HIZ;
        thr[k]        <= `PFMS_THR_RESET;
        settle_cnt[k] <= 14'd0;
      end
    end else begin
      for (k = 0; k < NPORT; k = k + 1) begin
        // Threshold applies after the settle time
        if (settle_cnt[k] != 14'd0) begin
          settle_cnt[k] <= settle_cnt[k] - 14'd1;
          if (settle_cnt[k] == 14'd1)
            settled[k] <= 1'b1;
        end
      end
      if (do_write) begin
        if (cfg_wr_port != 4'hf && w_strb[1])
          mode[cfg_wr_port] <= w_data[`PFMS_MODE_HI:`PFMS_MODE_LO];
        if (thr_wr_port != 4'hf && w_strb[1:0] == 2'b11) begin
          thr[thr_wr_port]        <= w_data[THR_W-1:0];
          settled[thr_wr_port]    <= 1'b0;
          settle_cnt[thr_wr_port] <= SETTLE_CYC[13:0];
        end
        if (aw_addr == `PFMS_EVT_MASK)
          evt_mask <= w_data[NPORT-1:0];
        if (aw_addr == `PFMS_IN_MODE)
          in_mode <= w_data[NPORT-1:0];
        if (aw_addr == `PFMS_IRQ_MASK)
          irq_mask <= w_data[NPORT-1:0];
      end
    end
  end

  // Pin synchroniser, filter, levels and sticky events
  always @(posedge aclk) begin
    if (!aresetn) begin
      sync1      <= {NPORT{1'b0}};
      sync2      <= {NPORT{1'b0}};
      sync3      <= {NPORT{1'b0}};
      stable     <= {NPORT{1'b0}};
      in_level   <= {NPORT{1'b0}};
      irq_status <= {NPORT{1'b0}};
    end else begin
      sync1 <= pin_above_thr;
      sync2 <= sync1;
      sync3 <= sync2;
      for (k = 0; k < NPORT; k = k + 1) begin
        // Change counts once the last two stages agree
        if (sync2[k] == sync3[k])
          stable[k] <= sync2[k];
        // Above threshold reads one; only in input modes
        if (is_input_mode(mode[k]) && in_mode[k] && settled[k])
          in_level[k] <= stable[k];
        else
          in_level[k] <= 1'b0;
        // Set wins over clear; masked ports raise nothing
        if (is_input_mode(mode[k]) && in_mode[k] && settled[k] &&
            !evt_mask[k] && stable[k] != in_level[k])
          irq_status[k] <= 1'b1;
        else if (do_write && aw_addr == `PFMS_IRQ_STATUS && w_data[k])
          irq_status[k] <= 1'b0;
      end
    end
  end

  // Pin drive per mode; translator drives the pair from each other
  always @(posedge aclk) begin
    if (!aresetn) begin
      pin_out   <= {NPORT{1'b0}};
      pin_oe    <= {NPORT{1'b0}};
      thr_level <= {NPORT*THR_W{1'b0}};
      xlat_rel  <= {NPORT{1'b0}};
    end else begin
      for (k = 0; k < NPORT; k = k + 1) begin
        thr_level[k*THR_W +: THR_W] <= thr[k];
        pin_out[k] <= 1'b0;
        pin_oe[k]  <= 1'b0; // High impedance by default
      end
      for (k = 0; k < NPORT - 1; k = k + 1) begin
        // Ports 5 and 11 never start a pair; the k != 5 test and the loop bound keep them off it
        if (mode[k] == `PFMS_MODE_XLAT && k != 5 &&
            mode[k+1] == `PFMS_MODE_HIZ) begin
          // Open-drain style: pull a high side low while the other is low, hold until it rises
          pin_oe[k]   <= !stable[k+1] && (pin_oe[k] ||
                         (stable[k] && !pin_oe[k+1] && !xlat_rel[k]));
          pin_oe[k+1] <= !stable[k] && (pin_oe[k+1] ||
                         (stable[k+1] && !pin_oe[k] && !xlat_rel[k]));
          // Our own release echoes low through the filter; lock out until both read high
          xlat_rel[k] <= (pin_oe[k] && stable[k+1]) || (pin_oe[k+1] && stable[k]) ||
                         (xlat_rel[k] && !(stable[k] && stable[k+1]));
        end
      end
    end
  end

  // Read decode, registered data
  always @* begin
    rd_mux      = 32'h0000_0000;
    rd_from_mem = 1'b0;
    mem_rd_addr = port_of(s_axi_araddr, `PFMS_CFG_BASE);
    if (do_write && cfg_wr_port != 4'hf)
      mem_rd_addr = cfg_wr_port;
    if (port_of(s_axi_araddr, `PFMS_CFG_BASE) != 4'hf)
      rd_from_mem = 1'b1;
    else if (port_of(s_axi_araddr, `PFMS_THR_BASE) != 4'hf)
      rd_mux[THR_W-1:0] = thr[port_of(s_axi_araddr, `PFMS_THR_BASE)];
    else if (s_axi_araddr == `PFMS_IN_DATA)
      rd_mux[NPORT-1:0] = in_level;
    else if (s_axi_araddr == `PFMS_EVT_MASK)
      rd_mux[NPORT-1:0] = evt_mask;
    else if (s_axi_araddr == `PFMS_IN_MODE)
      rd_mux[NPORT-1:0] = in_mode;
    else if (s_axi_araddr == `PFMS_IRQ_STATUS)
      rd_mux[NPORT-1:0] = irq_status;
    else if (s_axi_araddr == `PFMS_IRQ_MASK)
      rd_mux[NPORT-1:0] = irq_mask;
  end

  // Read channel: one wait cycle so memory data is registered
  always @(posedge aclk) begin
    if (!aresetn) begin
      rd_pend      <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'b00;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        rd_pend     <= rd_from_mem;
        s_axi_rdata <= rd_mux;
        s_axi_rvalid <= !rd_from_mem;
        s_axi_rresp <= (rd_from_mem || rd_mux != 32'h0 ||
                        port_of(s_axi_araddr, `PFMS_THR_BASE) != 4'hf ||
                        (s_axi_araddr >= `PFMS_IN_DATA &&
                         s_axi_araddr <= `PFMS_IRQ_MASK &&
                         s_axi_araddr[1:0] == 2'b00)) ? 2'b00 : 2'b11;
      end else if (rd_pend) begin
        rd_pend      <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {16'h0000, mem_rd_data};
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

// *** pfms_pin_env.sv ***
// Pin environment: pull-ups with external open-drain pullers
`timescale 1ns/1ps
module pfms_pin_env (
  // Drive from block and bench
  input  logic [11:0] pin_oe,
  input  logic [11:0] ext_low,
  // Comparator view
  output logic [11:0] pin_above_thr
);
  // Pull-up wins unless someone pulls low; threshold sits below pull-up
  assign pin_above_thr = ~(pin_oe | ext_low);
endmodule

// *** pfms_monitor.sv ***
// Port checker for the port mode block
`timescale 1ns/1ps
module pfms_monitor #(
  parameter NPORT = 12,
  parameter THR_W = 12
) (
  // Clock and reset
  input logic                   aclk,
  input logic                   aresetn,
  // Write channels
  input logic                   s_axi_awvalid,
  input logic                   s_axi_awready,
  input logic                   s_axi_wvalid,
  input logic                   s_axi_wready,
  input logic [1:0]             s_axi_bresp,
  input logic                   s_axi_bvalid,
  input logic                   s_axi_bready,
  // Read channels
  input logic                   s_axi_arvalid,
  input logic                   s_axi_arready,
  input logic [31:0]            s_axi_rdata,
  input logic                   s_axi_rvalid,
  input logic                   s_axi_rready,
  // Pins and interrupt
  input logic [NPORT-1:0]       pin_out,
  input logic [NPORT*THR_W-1:0] thr_level,
  input logic                   irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Data beat accepted
  logic wr_hs;
  assign wr_hs = s_axi_wvalid && s_axi_wready;
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && wr_hs;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  AST_OPEN_DRAIN: assert property (pin_out == '0)
    else $error("pin_out driven high");
  AST_WR_ANSWER: assert property (s_wr_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write not answered");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  AST_RD_ANSWER: assert property (s_rd_taken |-> ##[1:3] s_axi_rvalid)
    else $error("read not answered");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  AST_IRQ_QUIET: assert property ($rose(aresetn) |-> !irq)
    else $error("irq high after reset");
  AST_THR_CAUSE: assert property (!$stable(thr_level) |-> $past(wr_hs) || $past(wr_hs, 2) || $past(wr_hs, 3))
    else $error("threshold moved without write");
endmodule
bind pfms_port_mode pfms_monitor #(.NPORT(NPORT), .THR_W(THR_W)) u_mon (.aclk, .aresetn,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .pin_out, .thr_level, .irq);

// *** tb.sv ***
// Self-checking bench for the port mode block
`timescale 1ns/1ps
module tb;
  localparam int SC = 20; // Short settle time for simulation
  logic        aclk = 0;
  logic        aresetn = 0;
  logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic [31:0] s_axi_wdata = 0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  wire [1:0]   s_axi_bresp, s_axi_rresp;
  wire [31:0]  s_axi_rdata;
  wire [11:0]  pin_above_thr, pin_out, pin_oe;
  wire [143:0] thr_level;
  logic [11:0] ext_low = 0;   // External pullers per pin
  int          err_total = 0;
  int          samples_checked = 0;
  logic [31:0] rv;            // Last read data
  logic [1:0]  rr;            // Last read response
  logic [1:0]  br;            // Last write response

  // 100 ns clock
  always #50 aclk = ~aclk;

  pfms_port_mode #(.SETTLE_CYC(SC)) uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_above_thr, .pin_out, .pin_oe, .thr_level,
    .irq);
  pfms_pin_env env (.pin_oe, .ext_low, .pin_above_thr);

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // Write: offer both channels, drop each when taken, wait for response
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic ah, wh, bh;
    n = 0;
    bh = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (!bh && n < 50) begin
      @(negedge aclk);
      ah = s_axi_awvalid && s_axi_awready === 1'b1;
      wh = s_axi_wvalid && s_axi_wready === 1'b1;
      bh = s_axi_bvalid === 1'b1;
      br = s_axi_bresp;
      @(posedge aclk);
      if (ah) s_axi_awvalid <= 0;
      if (wh) s_axi_wvalid <= 0;
      n++;
    end
    s_axi_bready <= 0;
    if (!bh) begin
      err_total++;
      tally_and_finish();
    end
  endtask

  // Read: hold address until taken, wait for answer, capture data and response
  task automatic rd(input logic [7:0] a);
    int n;
    logic ah, hit;
    n = 0;
    hit = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    while (!hit && n < 50) begin
      @(negedge aclk);
      ah = s_axi_arvalid && s_axi_arready === 1'b1;
      hit = s_axi_rvalid === 1'b1;
      rv = s_axi_rdata;
      rr = s_axi_rresp;
      @(posedge aclk);
      if (ah) s_axi_arvalid <= 0;
      n++;
    end
    s_axi_rready <= 0;
    if (!hit) begin
      err_total++;
      tally_and_finish();
    end
  endtask

  // Reset values, mode field storage, unmapped access
  task automatic t_reset;
    rd(8'h00); chk("cfg0", 0, rv);
    rd(8'h64); chk("evt_mask", 32'hfff, rv);
    wr(8'h2c, 32'h1000); chk("bresp_ok", 0, {30'h0, br});
    rd(8'h2c); chk("cfg11", 32'h1000, rv);
    rd(8'h28); chk("cfg10", 0, rv);
    wr(8'h2c, 0);
    rd(8'hfc); chk("rresp", 32'h3, {30'h0, rr});
    wr(8'hfc, 0); chk("bresp_bad", 32'h3, {30'h0, br});
  endtask

  // Safe enable of a thresholded input on port 2, then events
  task automatic t_input;
    wr(8'h64, 32'hfff);
    wr(8'h38, 32'h123); wt(1); chk("thr2", 32'h123, {20'h0, thr_level[35:24]});
    wr(8'h08, 32'h1000);
    wr(8'h68, 32'h4);
    rd(8'h60); chk("in_early", 0, rv);
    wt(SC + 10);
    rd(8'h60); chk("in_high", 32'h4, rv);
    wr(8'h70, 32'h4);
    wr(8'h64, 32'hffb);
    ext_low[2] <= 1;
    wt(10);
    rd(8'h60); chk("in_low", 0, rv);
    chk("irq_set", 1, irq);
    rd(8'h6c); chk("status", 32'h4, rv);
    wr(8'h6c, 32'h4); wt(2); chk("irq_clr", 0, irq);
    wr(8'h64, 32'hfff);
    ext_low[2] <= 0;
    wt(10);
    chk("irq_masked", 0, irq);
    rd(8'h6c); chk("status_m", 0, rv);
  endtask

  // Translator pair 0/1, back to idle, illegal port 5
  task automatic t_xlat;
    wr(8'h30, 32'h100);
    wr(8'h34, 32'h100);
    wr(8'h00, 32'h2000);
    wr(8'h68, 32'h7);
    wt(SC + 10);
    rd(8'h60); chk("in_pre", 32'h5, rv);
    ext_low[0] <= 1;
    wt(10);
    chk("oe_pull", 32'h2, {20'h0, pin_oe});
    rd(8'h60); chk("in_xlat", 32'h4, rv);
    wr(8'h00, 0);
    ext_low[0] <= 0;
    wt(10);
    chk("oe_off", 0, {20'h0, pin_oe});
    wr(8'h14, 32'h2000);
    ext_low[5] <= 1;
    wt(10);
    chk("oe_p5", 0, {20'h0, pin_oe});
  endtask

  // Main sequence
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1;
    t_reset();
    t_input();
    t_xlat();
    tally_and_finish();
  end
endmodule
